// file: logic/delay_filter.sv
`timescale 1ns/10ps
// A condition passes only after it has held for the full count of cycles.
module delay_filter #(
   parameter int COUNT = 100
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cond,
   output logic hit
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   always_comb begin
      if (!cond) begin
         cnt_nxt = 16'h0000;
      end else if (cnt_r != 16'(COUNT)) begin
         cnt_nxt = cnt_r + 16'h0001;
      end else begin
         cnt_nxt = cnt_r;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign hit = cond && (cnt_r == 16'(COUNT));
endmodule

// file: logic/half_bridge_defs.svh
`ifndef HALF_BRIDGE_DEFS_SVH
`define HALF_BRIDGE_DEFS_SVH
`define WORD_BITS 16
`define CTL_CLEAR_BIT 0
`define CTL_SW_LO 1
`define CTL_SW_HI 6
`define CTL_OCS_BIT 13
`define STS_WARN_BIT 0
`define STS_SC_BIT 13
`define STS_OL_BIT 14
`define STS_SF_BIT 15
`define CTL_RESET_VALUE 16'h2000
`define UV_DELAY_NS 1000
`define UV_DELAY_CYC ((`UV_DELAY_NS + 9) / 10)
`define SD_DELAY_NS 1000
`define SD_DELAY_CYC ((`SD_DELAY_NS + 9) / 10)
`endif

// file: logic/half_bridge_pkg.sv
package half_bridge_pkg;
   typedef enum logic [2:0] {
      LINK_IDLE = 3'b001,
      LINK_SHIFT = 3'b010,
      LINK_FULL = 3'b100
   } link_state_t;
endpackage

// file: logic/half_bridge_serial_control.sv
`timescale 1ns/10ps
`include "half_bridge_defs.svh"
// Summary of operation
// - Chip select low starts; data sampled on falling clock.
// - Sixteen bits LSB first; applied at select rise.
// - Output tri-state when deselected; shifts on rising clock.
// - Clear bit clears supply, open-load, short flags.
// - Bits one to six switch the six stages.
// - Bit thirteen enables overcurrent shutdown.
// - Status bit zero reports temperature prewarning.
// - Status bits one to six show switch state.
// - Status bit thirteen flags overcurrent, with or without shutdown.
// - Status bit fourteen flags open load.
// - Status bit fifteen flags supply undervoltage.
// - Reset value: shutdown enabled, switches off, clear low.
// - Lasting undervoltage sets flag, disables outputs meanwhile.
// - Supply-fail flag holds until clear written.
// - Open-load flag needs delay, holds until clear.
// - Prewarning follows thermal hysteresis comparator itself.
// - Early select rise aborts, nothing changes.
// - Thermal shutdown latches off until cool and clear.
// - Enabled overcurrent turns stage off after delay.
// - Disabled shutdown flags overcurrent, keeps switches.
// - Clear resets short flag, re-enables tripped stages.
// - Inhibit low turns switches off, erases status.
// - Inhibit high restarts through internal reset.
module half_bridge_serial_control (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic inhibit_input,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo_out,
   output logic sdo_oe_n,
   input wire logic [5:0] overcurrent_in,
   input wire logic [5:0] low_current_in,
   input wire logic prewarn_in,
   input wire logic overtemp_in,
   input wire logic undervoltage_in,
   output logic [5:0] switch_on,
   output logic [5:0] switch_oe_n
);
   import half_bridge_pkg::*;

   // Pins are asynchronous to the clock; each goes through two stages first.
   logic [6:0] s1_r;
   logic [6:0] s2_r;
   logic [6:0] raw_pins;
   assign raw_pins = {inhibit_input, cs_n, sclk, sdi, prewarn_in, overtemp_in,
                      undervoltage_in};
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 7'h60;
         s2_r <= 7'h60;
      end else begin
         s1_r <= raw_pins;
         s2_r <= s1_r;
      end
   end
   logic [5:0] oc_s1_r;
   logic [5:0] oc_s2_r;
   logic [5:0] ol_s1_r;
   logic [5:0] ol_s2_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         oc_s1_r <= 6'h00;
         oc_s2_r <= 6'h00;
         ol_s1_r <= 6'h00;
         ol_s2_r <= 6'h00;
      end else begin
         oc_s1_r <= overcurrent_in;
         oc_s2_r <= oc_s1_r;
         ol_s1_r <= low_current_in;
         ol_s2_r <= ol_s1_r;
      end
   end
   logic inh_s;
   logic cs_s;
   logic clk_s;
   logic di_s;
   logic pw_s;
   logic ot_s;
   logic uv_s;
   assign inh_s = s2_r[6];
   assign cs_s = s2_r[5];
   assign clk_s = s2_r[4];
   assign di_s = s2_r[3];
   assign pw_s = s2_r[2];
   assign ot_s = s2_r[1];
   assign uv_s = s2_r[0];

   // Inhibit acts as a synchronous reset of all state except the input synchronizers, delay filters and clk_d_r; release is the power-on reset.
   logic run;
   assign run = inh_s;

   logic [15:0] ctl_r;
   logic [15:0] ctl_nxt;
   logic [15:0] sh_in_r;
   logic [15:0] sh_in_nxt;
   logic [15:0] sh_out_r;
   logic [15:0] sh_out_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic cs_d_r;
   logic clk_d_r;
   logic oe_n_r;
   logic oe_n_nxt;
   link_state_t st_r;
   link_state_t st_nxt;
   logic [5:0] trip_r;
   logic [5:0] trip_nxt;
   logic sc_r;
   logic sc_nxt;
   logic ol_r;
   logic ol_nxt;
   logic sf_r;
   logic sf_nxt;
   logic hot_r;
   logic hot_nxt;
   logic [5:0] sw_r;
   logic [5:0] sw_nxt;
   logic [15:0] status_word;
   logic clear_pulse;

   logic uv_hit;
   delay_filter #(.COUNT(`UV_DELAY_CYC)) uv_filter (
      .clock(clock),
      .rst_n(rst_n),
      .cond(uv_s),
      .hit(uv_hit)
   );

   logic [5:0] oc_hit;
   logic [5:0] ol_hit;
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : stage
         delay_filter #(.COUNT(`SD_DELAY_CYC)) oc_filter (
            .clock(clock),
            .rst_n(rst_n),
            .cond(oc_s2_r[g] && sw_r[g]),
            .hit(oc_hit[g])
         );
         delay_filter #(.COUNT(`SD_DELAY_CYC)) ol_filter (
            .clock(clock),
            .rst_n(rst_n),
            .cond(ol_s2_r[g] && sw_r[g]),
            .hit(ol_hit[g])
         );
      end
   endgenerate

   logic cs_fall;
   logic cs_rise;
   logic clk_fall;
   logic clk_rise;
   assign cs_fall = cs_d_r && !cs_s;
   assign cs_rise = !cs_d_r && cs_s;
   assign clk_fall = clk_d_r && !clk_s;
   assign clk_rise = !clk_d_r && clk_s;

   // Status view; the warning comes straight from the hysteresis comparator.
   always_comb begin
      status_word = 16'h0000;
      status_word[`STS_WARN_BIT] = pw_s;
      status_word[`CTL_SW_HI:`CTL_SW_LO] = sw_r;
      status_word[`STS_SC_BIT] = sc_r;
      status_word[`STS_OL_BIT] = ol_r;
      status_word[`STS_SF_BIT] = sf_r;
   end

   always_comb begin
      st_nxt = st_r;
      sh_in_nxt = sh_in_r;
      sh_out_nxt = sh_out_r;
      cnt_nxt = cnt_r;
      ctl_nxt = ctl_r;
      oe_n_nxt = oe_n_r;
      clear_pulse = 1'b0;
      case (st_r)
         LINK_IDLE: begin
            if (cs_fall) begin
               sh_out_nxt = status_word;
               cnt_nxt = 5'h00;
               oe_n_nxt = 1'b0;
               st_nxt = LINK_SHIFT;
            end
         end
         LINK_SHIFT, LINK_FULL: begin
            if (cs_rise) begin
               oe_n_nxt = 1'b1;
               st_nxt = LINK_IDLE;
               // A short frame is dropped so a prewarning poll changes nothing.
               if (st_r == LINK_FULL) begin
                  ctl_nxt = sh_in_r;
                  clear_pulse = sh_in_r[`CTL_CLEAR_BIT];
               end
            end else begin
               if (clk_fall) begin
                  sh_in_nxt = {di_s, sh_in_r[15:1]};
                  if (cnt_r != 5'h10) begin
                     cnt_nxt = cnt_r + 5'h01;
                  end
                  if (cnt_r >= 5'h0F) begin
                     st_nxt = LINK_FULL;
                  end
               end
               if (clk_rise && cnt_r != 5'h00) begin
                  sh_out_nxt = {1'b0, sh_out_r[15:1]};
               end
            end
         end
         default: begin
            st_nxt = LINK_IDLE;
            oe_n_nxt = 1'b1;
         end
      endcase
   end

   // Protection; a new event wins over a clear in the same cycle.
   always_comb begin
      trip_nxt = trip_r;
      sc_nxt = sc_r;
      ol_nxt = ol_r;
      sf_nxt = sf_r;
      hot_nxt = hot_r;
      if (clear_pulse) begin
         trip_nxt = 6'h00;
         sc_nxt = 1'b0;
         ol_nxt = 1'b0;
         sf_nxt = 1'b0;
         if (!ot_s) begin
            hot_nxt = 1'b0;
         end
      end
      if (ot_s) begin
         hot_nxt = 1'b1;
      end
      if (|oc_hit) begin
         sc_nxt = 1'b1;
         if (ctl_r[`CTL_OCS_BIT]) begin
            trip_nxt = trip_nxt | oc_hit;
         end
      end
      if (|ol_hit) begin
         ol_nxt = 1'b1;
      end
      if (uv_hit) begin
         sf_nxt = 1'b1;
      end
   end

   // Undervoltage gates outputs only while present, so recovery is immediate.
   always_comb begin
      if (hot_r || uv_hit) begin
         sw_nxt = 6'h00;
      end else begin
         sw_nxt = ctl_r[`CTL_SW_HI:`CTL_SW_LO] & ~trip_r;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= LINK_IDLE;
         sh_in_r <= 16'h0000;
         sh_out_r <= 16'h0000;
         cnt_r <= 5'h00;
         ctl_r <= `CTL_RESET_VALUE;
         oe_n_r <= 1'b1;
         cs_d_r <= 1'b1;
         clk_d_r <= 1'b0;
         trip_r <= 6'h00;
         sc_r <= 1'b0;
         ol_r <= 1'b0;
         sf_r <= 1'b0;
         hot_r <= 1'b0;
         sw_r <= 6'h00;
      end else if (!run) begin
         st_r <= LINK_IDLE;
         sh_in_r <= 16'h0000;
         sh_out_r <= 16'h0000;
         cnt_r <= 5'h00;
         ctl_r <= `CTL_RESET_VALUE;
         oe_n_r <= 1'b1;
         cs_d_r <= 1'b1;
         clk_d_r <= clk_s;
         trip_r <= 6'h00;
         sc_r <= 1'b0;
         ol_r <= 1'b0;
         sf_r <= 1'b0;
         hot_r <= 1'b0;
         sw_r <= 6'h00;
      end else begin
         st_r <= st_nxt;
         sh_in_r <= sh_in_nxt;
         sh_out_r <= sh_out_nxt;
         cnt_r <= cnt_nxt;
         ctl_r <= ctl_nxt;
         oe_n_r <= oe_n_nxt;
         cs_d_r <= cs_s;
         clk_d_r <= clk_s;
         trip_r <= trip_nxt;
         sc_r <= sc_nxt;
         ol_r <= ol_nxt;
         sf_r <= sf_nxt;
         hot_r <= hot_nxt;
         sw_r <= sw_nxt;
      end
   end

   assign sdo_out = sh_out_r[0];
   assign sdo_oe_n = oe_n_r;
   assign switch_on = sw_r;
   assign switch_oe_n = {6{~run}};
endmodule

// file: test/half_bridge_properties.sv
`timescale 1ns/10ps
module half_bridge_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic inhibit_input,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdo_out,
   input wire logic sdo_oe_n,
   input wire logic [5:0] overcurrent_in,
   input wire logic overtemp_in,
   input wire logic undervoltage_in,
   input wire logic [5:0] switch_on,
   input wire logic [5:0] switch_oe_n
);
   logic [7:0] uv_cnt_r;
   logic [7:0] uv_cnt_nxt;
   logic quiet;
   // The count saturates so a long undervoltage cannot wrap back below the limit.
   always_comb begin
      uv_cnt_nxt = 8'h00;
      if (undervoltage_in) begin
         uv_cnt_nxt = (uv_cnt_r == 8'hFF) ? uv_cnt_r : uv_cnt_r + 8'h01;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         uv_cnt_r <= 8'h00;
      end else begin
         uv_cnt_r <= uv_cnt_nxt;
      end
   end
   assign quiet = !cs_n && inhibit_input && !overtemp_in && !undervoltage_in
      && overcurrent_in == 6'h00;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_sdo_idle: assert property (cs_n [*8] |-> sdo_oe_n)
      else $error("sdo driven while idle");
   a_sdo_drive: assert property ((!cs_n && inhibit_input) [*8] |-> !sdo_oe_n)
      else $error("sdo not driven");
   a_sdo_steady: assert property ((!cs_n && !sclk) [*8] |=> $stable(sdo_out))
      else $error("sdo moved without clock");
   a_inh_float: assert property (!inhibit_input [*6] |-> &switch_oe_n)
      else $error("switch driven in standby");
   a_inh_off: assert property (!inhibit_input [*6] |-> switch_on == 6'h00)
      else $error("switch on in standby");
   a_uv_off: assert property (uv_cnt_r > 8'h6E |-> switch_on == 6'h00)
      else $error("switch on in undervoltage");
   a_hot_off: assert property (overtemp_in [*6] |-> switch_on == 6'h00)
      else $error("switch on while hot");
   a_sw_quiet: assert property (quiet [*8] |=> $stable(switch_on))
      else $error("switch moved mid frame");
   a_reset_off: assert property ($rose(rst_n) |-> switch_on == 6'h00 && sdo_oe_n)
      else $error("bad reset state");
   c_frame: cover property (!cs_n ##1 cs_n);
   c_uv: cover property (uv_cnt_r == 8'h6F);
   c_hot: cover property (overtemp_in && switch_on == 6'h00);
endmodule
bind half_bridge_serial_control half_bridge_checker i_chk (.clock, .rst_n, .inhibit_input,
   .cs_n, .sclk, .sdo_out, .sdo_oe_n, .overcurrent_in, .overtemp_in, .undervoltage_in,
   .switch_on, .switch_oe_n);

// file: test/half_bridge_serial_control_tb.sv
`timescale 1ns/10ps
module half_bridge_serial_control_tb;
   typedef struct packed {
      logic [15:0] ctl;
      logic [5:0] sw;
   } row_t;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic inhibit_input = 1'b1;
   logic [5:0] overcurrent_in = 6'h00;
   logic [5:0] low_current_in = 6'h00;
   logic prewarn_in = 1'b0;
   logic overtemp_in = 1'b0;
   logic undervoltage_in = 1'b0;
   logic cs_n, sclk, sdi, sdo_out, sdo_oe_n;
   logic [5:0] switch_on, switch_oe_n;
   logic [5:0] prev = 6'h00;
   logic [15:0] st;
   int num_errors = 0;
   int checked = 0;
   row_t rows [8] = '{'{16'h2002, 6'h01}, '{16'h2004, 6'h02}, '{16'h2008, 6'h04},
      '{16'h2010, 6'h08}, '{16'h2020, 6'h10}, '{16'h2040, 6'h20},
      '{16'h207E, 6'h3F}, '{16'h2002, 6'h01}};
   // The data line has no pull, so a released line shows the inverse of the last bit.
   wire sdo = sdo_oe_n ? ~sdo_out : sdo_out;
   always #5 clock = ~clock;
   half_bridge_serial_control i_dut (.clock, .rst_n, .inhibit_input, .cs_n, .sclk, .sdi,
      .sdo_out, .sdo_oe_n, .overcurrent_in, .low_current_in, .prewarn_in, .overtemp_in,
      .undervoltage_in, .switch_on, .switch_oe_n);
   host_link_model i_host (.cs_n, .sclk, .sdi, .sdo);
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [15:0] w);
      i_host.xfer(w, 16, st);
   endtask
   task automatic pulse(input int n, input logic [5:0] oc, input logic [5:0] lc);
      overcurrent_in <= oc;
      low_current_in <= lc;
      cyc(n);
      overcurrent_in <= 6'h00;
      low_current_in <= 6'h00;
   endtask
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end
   initial begin
      cyc(2);
      rst_n <= 1'b1;
      cyc(3);
      chk("reset sw", 16'(switch_on), 16'h0000);
      wr(16'h0000);
      chk("reset st", st, 16'h0000);
      chk("oe idle", 16'(sdo_oe_n), 16'h0001);
      foreach (rows[i]) begin
         wr(rows[i].ctl);
         chk("switch", 16'(switch_on), 16'(rows[i].sw));
         chk("state bits", 16'(st[6:1]), 16'(prev));
         prev = rows[i].sw;
      end
      prewarn_in <= 1'b1;
      cyc(5);
      i_host.xfer(16'h0000, 0, st);
      chk("prewarn", 16'(st[0]), 16'h0001);
      i_host.xfer(16'h0000, 8, st);
      chk("abort", 16'(switch_on), 16'h0001);
      prewarn_in <= 1'b0;
      pulse(150, 6'h01, 6'h00);
      chk("oc trip", 16'(switch_on), 16'h0000);
      wr(16'h2002);
      chk("oc flag", st, 16'h2000);
      wr(16'h0003);
      chk("oc clear", 16'(switch_on), 16'h0001);
      pulse(150, 6'h01, 6'h01);
      chk("oc kept", 16'(switch_on), 16'h0001);
      wr(16'h0003);
      chk("flags", st, 16'h6002);
      pulse(50, 6'h00, 6'h01);
      wr(16'h0002);
      chk("cleared", st, 16'h0002);
      undervoltage_in <= 1'b1;
      cyc(150);
      chk("uv off", 16'(switch_on), 16'h0000);
      undervoltage_in <= 1'b0;
      cyc(10);
      chk("uv back", 16'(switch_on), 16'h0001);
      overtemp_in <= 1'b1;
      cyc(10);
      overtemp_in <= 1'b0;
      wr(16'h0002);
      chk("hot latch", st, 16'h8000);
      inhibit_input <= 1'b0;
      cyc(10);
      chk("inh float", 16'(switch_oe_n), 16'h003F);
      inhibit_input <= 1'b1;
      cyc(5);
      wr(16'h0002);
      chk("inh erased", st, 16'h0000);
      chk("inh run", 16'(switch_on), 16'h0001);
      chk("inh drive", 16'(switch_oe_n), 16'h0000);
      overtemp_in <= 1'b1;
      cyc(10);
      overtemp_in <= 1'b0;
      wr(16'h0003);
      chk("hot cool", st, 16'h0000);
      chk("hot back", 16'(switch_on), 16'h0001);
      complete_run();
   end
endmodule

// file: test/host_link_model.sv
`timescale 1ns/10ps
// Host end of the serial link; between frames select rests high and clock and data rest low.
module host_link_model (
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // Only the low n bits of the word are sent, so short frames and empty polls are possible.
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] st);
      st = 16'h0000;
      cs_n <= 1'b0;
      #100;
      st[0] = sdo;
      for (int i = 0; i < n; i++) begin
         #62.5 sclk <= 1'b1;
         // Data moves well clear of the falling edge, since both pins are resampled.
         #30 sdi <= w[i];
         #32.5 sclk <= 1'b0;
         st[i] = sdo;
      end
      #62.5 sdi <= 1'b0;
      cs_n <= 1'b1;
      #100;
   endtask
endmodule
